// *** shared/acwin_params.svh ***
/*
 * Constants of the comparator window register bank: register indexes,
 * writable-bit masks, field positions, reset values and fixed figures.
 * Assumes inclusion by bare name from packages and modules.
 */
`ifndef ACWIN_PARAMS_SVH
`define ACWIN_PARAMS_SVH

////////////////////////////////////////////////////////////////////////////////
// Register indexes; byte address is four times the index
`define ACWIN_IDX_CMP0_CTRL    8'h00
`define ACWIN_IDX_CMP1_CTRL    8'h01
`define ACWIN_IDX_CMP0_INSEL   8'h02
`define ACWIN_IDX_CMP1_INSEL   8'h03
`define ACWIN_IDX_INVERT       8'h04
`define ACWIN_IDX_SCALER       8'h05
`define ACWIN_IDX_WINDOW       8'h06
`define ACWIN_IDX_STATUS       8'h07
`define ACWIN_IDX_CURR_CTRL    8'h08
`define ACWIN_IDX_CURR_TRIM    8'h09
`define ACWIN_IDX_IRQ_MASK     8'h0A
`define ACWIN_IDX_LAST         8'h0A

////////////////////////////////////////////////////////////////////////////////
// Writable bits per register; the rest read as zero
`define ACWIN_WMASK_CMP_CTRL   8'hF7
`define ACWIN_WMASK_INSEL      8'h3F
`define ACWIN_WMASK_INVERT     8'h0F
`define ACWIN_WMASK_SCALER     8'h3F
`define ACWIN_WMASK_WINDOW     8'h1F
`define ACWIN_WMASK_CURR_CTRL  8'hC3
`define ACWIN_WMASK_CURR_TRIM  8'h0F
`define ACWIN_WMASK_FLAGS      8'h07

////////////////////////////////////////////////////////////////////////////////
// Field positions
`define ACWIN_CTRL_ENABLE      0
`define ACWIN_CTRL_HYST_LO     1
`define ACWIN_CTRL_LVL_LO      4
`define ACWIN_CTRL_EDGE_LO     6
`define ACWIN_INSEL_NEG_LO     0
`define ACWIN_INSEL_POS_LO     3
`define ACWIN_INV_CMP0         2
`define ACWIN_INV_CMP1         3
`define ACWIN_INV_PIN0         0
`define ACWIN_INV_PIN1         1
`define ACWIN_WIN_LVL_LO       0
`define ACWIN_WIN_COND_LO      2
`define ACWIN_WIN_ENABLE       4
`define ACWIN_ST_FLAG_CMP0     0
`define ACWIN_ST_FLAG_CMP1     1
`define ACWIN_ST_FLAG_WIN      2
`define ACWIN_ST_LIVE0         4
`define ACWIN_ST_LIVE1         5
`define ACWIN_ST_POS_LO        6
`define ACWIN_CUR_OUT0         0
`define ACWIN_CUR_OUT1         1
`define ACWIN_CUR_DOUBLE       6
`define ACWIN_CUR_ENABLE       7

////////////////////////////////////////////////////////////////////////////////
// Reset values and fixed figures
`define ACWIN_RST_BYTE         8'h00
`define ACWIN_RST_WORD         32'h0000_0000
`define ACWIN_SCALE_DIVISOR    7'h40
`define ACWIN_LVL_OFF          2'h0

`endif

// *** shared/acwin_pkg.sv ***
/*
 * Types of the comparator window register bank.
 * Assumes acwin_params.svh on the include path.
 */
`include "acwin_params.svh"

package acwin_pkg;

    typedef enum logic [1:0] {
        ACWIN_POS_ABOVE,
        ACWIN_POS_INSIDE,
        ACWIN_POS_BELOW,
        ACWIN_POS_OUTSIDE
    } acwin_pos_e;

    typedef enum logic [1:0] {
        ACWIN_EDGE_TOGGLE,
        ACWIN_EDGE_RESERVED,
        ACWIN_EDGE_FALLING,
        ACWIN_EDGE_RISING
    } acwin_edge_e;

    typedef struct packed {
        logic [2:0] sync;
        logic       filt;
    } acwin_edge_s;

    typedef struct packed {
        logic [7:0]  cmp_ctrl0;
        logic [7:0]  cmp_ctrl1;
        logic [7:0]  insel0;
        logic [7:0]  insel1;
        logic [7:0]  invert;
        logic [7:0]  scaler;
        logic [7:0]  window;
        logic [7:0]  flags;
        logic [7:0]  curr_ctrl;
        logic [7:0]  curr_trim;
        logic [7:0]  irq_mask;
        logic        win_match;
        logic [1:0]  wpos;
        logic [6:0]  scale_num;
        logic [2:0]  irq_req;
        logic        irq;
        logic        pready;
        logic        pslverr;
        logic [31:0] prdata;
    } acwin_regs_s;

endpackage : acwin_pkg

// *** shared/acwin_edge_if.sv ***
/*
 * Carrier between the register bank and one comparator edge detector.
 * Assumes both ends on the same pclk.
 */
`timescale 1ns/1ps

interface acwin_edge_if;
    import acwin_pkg::*;
    logic        raw;
    logic        enable;
    logic        invert;
    acwin_edge_e mode;
    logic        level;
    logic        event_p;

    modport owner (output raw, output enable, output invert, output mode,
                   input level, input event_p);
    modport det   (input raw, input enable, input invert, input mode,
                   output level, output event_p);
endinterface : acwin_edge_if

// *** src/acwin_edge.sv ***
/*
 * One comparator output: three-stage synchroniser, glitch filter, optional
 * inversion and edge-mode event.
 * Assumes the raw level is asynchronous to pclk.
 */
`timescale 1ns/1ps

module acwin_edge
    import acwin_pkg::*;
(
    // Clock and reset
    input  wire logic  pclk,
    input  wire logic  presetn,
    // Owner side
    acwin_edge_if.det  port
);

    acwin_edge_s r_r;
    acwin_edge_s r_nxt;
    logic        new_filt;
    logic        old_lvl;
    logic        new_lvl;

    always_comb begin
        r_nxt      = r_r;
        r_nxt.sync = {r_r.sync[1:0], port.raw};
        // Change only once the second and third stages agree
        new_filt   = (r_r.sync[1] == r_r.sync[2]) ? r_r.sync[2] : r_r.filt;
        r_nxt.filt = new_filt;
        // Same invert on both sides so flipping it alone makes no edge
        old_lvl    = r_r.filt ^ port.invert;
        new_lvl    = new_filt ^ port.invert;
        port.level = old_lvl;
        port.event_p = 1'b0;
        if (port.enable) begin
            unique case (port.mode)
                ACWIN_EDGE_TOGGLE:   port.event_p = old_lvl ^ new_lvl;
                ACWIN_EDGE_RESERVED: port.event_p = 1'b0;
                ACWIN_EDGE_FALLING:  port.event_p = old_lvl & ~new_lvl;
                ACWIN_EDGE_RISING:   port.event_p = ~old_lvl & new_lvl;
            endcase
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            r_r <= '0;
        end else begin
            r_r <= r_nxt;
        end
    end

endmodule : acwin_edge

// *** src/acwin_regs.sv ***
/*
 * Register bank of a dual comparator with window mode, current source and
 * interrupt flags, reached over APB.
 * Assumes an analog front end that consumes the control outputs and drives
 * the two raw comparator levels, and an interrupt controller that pulses
 * the vector acknowledge inputs on pclk.
 */
// Design decision made here: the APB register port.
`timescale 1ns/1ps

module acwin_regs
    import acwin_pkg::*;
#(
    parameter int ADDR_W = 12
) (
    // Clock and reset
    input  wire logic              pclk,
    input  wire logic              presetn,
    // APB slave
    input  wire logic              psel,
    input  wire logic              penable,
    input  wire logic              pwrite,
    input  wire logic [ADDR_W-1:0] paddr,
    input  wire logic [31:0]       pwdata,
    input  wire logic [3:0]        pstrb,
    output logic [31:0]            prdata,
    output logic                   pready,
    output logic                   pslverr,
    // Comparator raw levels from the analog front end
    input  wire logic              cmp0_raw,
    input  wire logic              cmp1_raw,
    // Vector acknowledge pulses: bit 0 cmp0, bit 1 cmp1, bit 2 window
    input  wire logic [2:0]        vector_ack,
    // Comparator controls
    output logic [1:0]             cmp0_enable_hyst_unused_n,
    output logic                   cmp0_enable,
    output logic                   cmp1_enable,
    output logic [1:0]             cmp0_hysteresis,
    output logic [1:0]             cmp1_hysteresis,
    output logic [2:0]             cmp0_positive_input_select,
    output logic [2:0]             cmp1_positive_input_select,
    output logic [2:0]             cmp0_negative_input_select,
    output logic [2:0]             cmp1_negative_input_select,
    output logic                   cmp0_pin_out,
    output logic                   cmp1_pin_out,
    output logic                   window_enable,
    output logic [6:0]             scale_numerator,
    // Current source
    output logic                   current_enable,
    output logic                   current_double,
    output logic                   cmp0_source_out,
    output logic                   cmp1_source_out,
    output logic [3:0]             source_trim_value,
    // Interrupts
    output logic [2:0]             irq_request,
    output logic [1:0]             cmp0_irq_priority,
    output logic [1:0]             cmp1_irq_priority,
    output logic [1:0]             window_irq_priority,
    output logic                   irq
);

    ////////////////////////////////////////////////////////////////////////////
    // Parameter check

    if (ADDR_W < 6) begin : g_bad_addr_w
        $error("acwin_regs: ADDR_W too small for the register map");
    end

    ////////////////////////////////////////////////////////////////////////////
    // Helpers

    function automatic logic [7:0] keep_bits(input logic [7:0] data,
                                             input logic [7:0] mask);
        keep_bits = data & mask;
    endfunction : keep_bits

    function automatic logic idx_is(input logic [ADDR_W-3:0] idx,
                                    input logic [7:0]        want);
        idx_is = (idx == (ADDR_W-2)'(want));
    endfunction : idx_is

    function automatic logic win_hit(input acwin_pos_e pos,
                                     input logic [1:0] cond);
        unique case (cond)
            2'h0:    win_hit = (pos == ACWIN_POS_ABOVE);
            2'h1:    win_hit = (pos == ACWIN_POS_INSIDE);
            2'h2:    win_hit = (pos == ACWIN_POS_BELOW);
            default: win_hit = (pos != ACWIN_POS_INSIDE);
        endcase
    endfunction : win_hit

    ////////////////////////////////////////////////////////////////////////////
    // Comparator edge detectors

    acwin_edge_if cmp0_if ();
    acwin_edge_if cmp1_if ();

    acwin_edge u_edge0 (
        .pclk    (pclk),
        .presetn (presetn),
        .port    (cmp0_if.det)
    );

    acwin_edge u_edge1 (
        .pclk    (pclk),
        .presetn (presetn),
        .port    (cmp1_if.det)
    );

    acwin_regs_s r_r;
    acwin_regs_s r_nxt;

    assign cmp0_if.raw    = cmp0_raw;
    assign cmp1_if.raw    = cmp1_raw;
    assign cmp0_if.enable = r_r.cmp_ctrl0[`ACWIN_CTRL_ENABLE];
    assign cmp1_if.enable = r_r.cmp_ctrl1[`ACWIN_CTRL_ENABLE];
    assign cmp0_if.invert = r_r.invert[`ACWIN_INV_CMP0];
    assign cmp1_if.invert = r_r.invert[`ACWIN_INV_CMP1];
    assign cmp0_if.mode   = acwin_edge_e'(r_r.cmp_ctrl0[`ACWIN_CTRL_EDGE_LO +: 2]);
    assign cmp1_if.mode   = acwin_edge_e'(r_r.cmp_ctrl1[`ACWIN_CTRL_EDGE_LO +: 2]);

    ////////////////////////////////////////////////////////////////////////////
    // Next state

    logic [ADDR_W-3:0] idx;
    logic              mapped;
    logic              setup;
    logic              wr;
    logic [7:0]        wb;
    logic [7:0]        rd;
    acwin_pos_e        pos_now;
    logic              hit_now;
    logic [2:0]        set_ev;
    logic [2:0]        clr_ev;
    logic [2:0]        lvl_on;

    always_comb begin
        r_nxt   = r_r;
        idx     = paddr[ADDR_W-1:2];
        mapped  = (idx <= (ADDR_W-2)'(`ACWIN_IDX_LAST));
        setup   = psel & ~penable & ~r_r.pready;
        wr      = psel & penable & r_r.pready & pwrite & pstrb[0] & mapped;
        wb      = pwdata[7:0];

        // Cmp0 above upper bound, cmp1 above lower bound
        if (cmp0_if.level & cmp1_if.level) begin
            pos_now = ACWIN_POS_ABOVE;
        end else if (~cmp0_if.level & cmp1_if.level) begin
            pos_now = ACWIN_POS_INSIDE;
        end else if (~cmp0_if.level & ~cmp1_if.level) begin
            pos_now = ACWIN_POS_BELOW;
        end else begin
            pos_now = ACWIN_POS_OUTSIDE;
        end
        hit_now = r_r.window[`ACWIN_WIN_ENABLE]
                & win_hit(pos_now, r_r.window[`ACWIN_WIN_COND_LO +: 2]);
        r_nxt.win_match = hit_now;
        // Position shown only in window mode
        r_nxt.wpos = r_r.window[`ACWIN_WIN_ENABLE] ? pos_now : ACWIN_POS_ABOVE;

        // Flag events; set wins over a clear in the same cycle
        set_ev = {hit_now & ~r_r.win_match,
                  cmp1_if.event_p,
                  cmp0_if.event_p};
        clr_ev = vector_ack;
        if (wr && idx_is(idx, `ACWIN_IDX_STATUS)) begin
            clr_ev = clr_ev | wb[2:0];
        end
        r_nxt.flags[2:0] = (r_r.flags[2:0] & ~clr_ev) | set_ev;

        // Register writes; reserved bits dropped
        if (wr) begin
            if (idx_is(idx, `ACWIN_IDX_CMP0_CTRL)) begin
                r_nxt.cmp_ctrl0 = keep_bits(wb, `ACWIN_WMASK_CMP_CTRL);
            end
            if (idx_is(idx, `ACWIN_IDX_CMP1_CTRL)) begin
                r_nxt.cmp_ctrl1 = keep_bits(wb, `ACWIN_WMASK_CMP_CTRL);
            end
            if (idx_is(idx, `ACWIN_IDX_CMP0_INSEL)) begin
                r_nxt.insel0 = keep_bits(wb, `ACWIN_WMASK_INSEL);
            end
            if (idx_is(idx, `ACWIN_IDX_CMP1_INSEL)) begin
                r_nxt.insel1 = keep_bits(wb, `ACWIN_WMASK_INSEL);
            end
            if (idx_is(idx, `ACWIN_IDX_INVERT)) begin
                r_nxt.invert = keep_bits(wb, `ACWIN_WMASK_INVERT);
            end
            if (idx_is(idx, `ACWIN_IDX_SCALER)) begin
                r_nxt.scaler = keep_bits(wb, `ACWIN_WMASK_SCALER);
            end
            if (idx_is(idx, `ACWIN_IDX_WINDOW)) begin
                r_nxt.window = keep_bits(wb, `ACWIN_WMASK_WINDOW);
            end
            if (idx_is(idx, `ACWIN_IDX_CURR_CTRL)) begin
                r_nxt.curr_ctrl = keep_bits(wb, `ACWIN_WMASK_CURR_CTRL);
            end
            if (idx_is(idx, `ACWIN_IDX_CURR_TRIM)) begin
                r_nxt.curr_trim = keep_bits(wb, `ACWIN_WMASK_CURR_TRIM);
            end
            if (idx_is(idx, `ACWIN_IDX_IRQ_MASK)) begin
                r_nxt.irq_mask = keep_bits(wb, `ACWIN_WMASK_FLAGS);
            end
        end

        // Scaled reference numerator; denominator is fixed
        r_nxt.scale_num = {1'b0, r_nxt.scaler[5:0]} + 7'h01;

        // Requests from flag and nonzero level
        lvl_on = {r_nxt.window[`ACWIN_WIN_LVL_LO +: 2] != `ACWIN_LVL_OFF,
                  r_nxt.cmp_ctrl1[`ACWIN_CTRL_LVL_LO +: 2] != `ACWIN_LVL_OFF,
                  r_nxt.cmp_ctrl0[`ACWIN_CTRL_LVL_LO +: 2] != `ACWIN_LVL_OFF};
        r_nxt.irq_req = r_nxt.flags[2:0] & lvl_on;
        r_nxt.irq     = |(r_nxt.flags[2:0] & r_nxt.irq_mask[2:0]);

        // Read mux
        rd = `ACWIN_RST_BYTE;
        unique case (1'b1)
            idx_is(idx, `ACWIN_IDX_CMP0_CTRL):  rd = r_r.cmp_ctrl0;
            idx_is(idx, `ACWIN_IDX_CMP1_CTRL):  rd = r_r.cmp_ctrl1;
            idx_is(idx, `ACWIN_IDX_CMP0_INSEL): rd = r_r.insel0;
            idx_is(idx, `ACWIN_IDX_CMP1_INSEL): rd = r_r.insel1;
            idx_is(idx, `ACWIN_IDX_INVERT):     rd = r_r.invert;
            idx_is(idx, `ACWIN_IDX_SCALER):     rd = r_r.scaler;
            idx_is(idx, `ACWIN_IDX_WINDOW):     rd = r_r.window;
            idx_is(idx, `ACWIN_IDX_STATUS): begin
                rd = r_r.flags;
                rd[`ACWIN_ST_POS_LO +: 2] = r_r.wpos;
                rd[`ACWIN_ST_LIVE1]       = cmp1_if.level;
                rd[`ACWIN_ST_LIVE0]       = cmp0_if.level;
            end
            idx_is(idx, `ACWIN_IDX_CURR_CTRL):  rd = r_r.curr_ctrl;
            idx_is(idx, `ACWIN_IDX_CURR_TRIM):  rd = r_r.curr_trim;
            idx_is(idx, `ACWIN_IDX_IRQ_MASK):   rd = r_r.irq_mask;
            default:                            rd = `ACWIN_RST_BYTE;
        endcase

        // No wait state: answer prepared in setup, shown in the first access cycle
        if (setup) begin
            r_nxt.pready  = 1'b1;
            r_nxt.pslverr = ~mapped;
            r_nxt.prdata  = (mapped & ~pwrite) ? {24'h00_0000, rd} : `ACWIN_RST_WORD;
        end else if (r_r.pready) begin
            r_nxt.pready  = 1'b0;
            r_nxt.pslverr = 1'b0;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // State register

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            r_r <= '0;
        end else begin
            r_r <= r_nxt;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Outputs, all straight from flip-flops except cmp0_enable_hyst_unused_n, tied to zero

    assign prdata                     = r_r.prdata;
    assign pready                     = r_r.pready;
    assign pslverr                    = r_r.pslverr;
    assign cmp0_enable_hyst_unused_n  = 2'h0;
    assign cmp0_enable                = r_r.cmp_ctrl0[`ACWIN_CTRL_ENABLE];
    assign cmp1_enable                = r_r.cmp_ctrl1[`ACWIN_CTRL_ENABLE];
    assign cmp0_hysteresis            = r_r.cmp_ctrl0[`ACWIN_CTRL_HYST_LO +: 2];
    assign cmp1_hysteresis            = r_r.cmp_ctrl1[`ACWIN_CTRL_HYST_LO +: 2];
    assign cmp0_positive_input_select = r_r.insel0[`ACWIN_INSEL_POS_LO +: 3];
    assign cmp1_positive_input_select = r_r.insel1[`ACWIN_INSEL_POS_LO +: 3];
    assign cmp0_negative_input_select = r_r.insel0[`ACWIN_INSEL_NEG_LO +: 3];
    assign cmp1_negative_input_select = r_r.insel1[`ACWIN_INSEL_NEG_LO +: 3];
    assign cmp0_pin_out               = r_r.invert[`ACWIN_INV_PIN0];
    assign cmp1_pin_out               = r_r.invert[`ACWIN_INV_PIN1];
    assign window_enable              = r_r.window[`ACWIN_WIN_ENABLE];
    assign scale_numerator            = r_r.scale_num;
    assign current_enable             = r_r.curr_ctrl[`ACWIN_CUR_ENABLE];
    assign current_double             = r_r.curr_ctrl[`ACWIN_CUR_DOUBLE];
    assign cmp0_source_out            = r_r.curr_ctrl[`ACWIN_CUR_OUT0];
    assign cmp1_source_out            = r_r.curr_ctrl[`ACWIN_CUR_OUT1];
    assign source_trim_value          = r_r.curr_trim[3:0];
    assign irq_request                = r_r.irq_req;
    assign cmp0_irq_priority          = r_r.cmp_ctrl0[`ACWIN_CTRL_LVL_LO +: 2];
    assign cmp1_irq_priority          = r_r.cmp_ctrl1[`ACWIN_CTRL_LVL_LO +: 2];
    assign window_irq_priority        = r_r.window[`ACWIN_WIN_LVL_LO +: 2];
    assign irq                        = r_r.irq;

endmodule : acwin_regs

// *** tb/acwin_regs_chk.sv ***
/* Concurrent checks on the comparator window bank top ports.
   Assumes a bind from the bench top file and a single pclk domain. */
`timescale 1ns/1ps
`include "acwin_params.svh"

module acwin_regs_chk #(
    parameter int ADDR_W = 12
) (
    // Clock, reset and bus
    input wire logic              pclk,
    input wire logic              presetn,
    input wire logic              psel,
    input wire logic              penable,
    input wire logic              pwrite,
    input wire logic [ADDR_W-1:0] paddr,
    input wire logic [31:0]       pwdata,
    input wire logic [3:0]        pstrb,
    input wire logic              pready,
    input wire logic              pslverr,
    // Controls and interrupts
    input wire logic [6:0]        scale_numerator,
    input wire logic              window_enable,
    input wire logic              current_enable,
    input wire logic              current_double,
    input wire logic              cmp0_source_out,
    input wire logic              cmp1_source_out,
    input wire logic [3:0]        source_trim_value,
    input wire logic [2:0]        irq_request,
    input wire logic [1:0]        window_irq_priority
);
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    ////////////////////////////////////////////////////////////////////////////////
    // Last accepted write byte; outputs may lag it by one register stage
    logic       wr;
    logic [7:0] idx;
    logic [7:0] wd_r;
    assign wr  = psel && penable && pready && pwrite && pstrb[0] && !pslverr;
    assign idx = 8'(paddr[ADDR_W-1:2]);
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            wd_r <= 8'h00;
        end else if (wr) begin
            wd_r <= pwdata[7:0];
        end
    end
    ////////////////////////////////////////////////////////////////////////////////
    chk_scale_num: assert property (wr && idx == `ACWIN_IDX_SCALER |=> ##[0:1]
        scale_numerator == {1'b0, wd_r[5:0]} + 7'h01) else $error("scaler numerator wrong");
    chk_window_en: assert property (wr && idx == `ACWIN_IDX_WINDOW |=> ##[0:1]
        window_enable == wd_r[4]) else $error("window enable wrong");
    chk_window_prio: assert property (wr && idx == `ACWIN_IDX_WINDOW |=> ##[0:1]
        window_irq_priority == wd_r[1:0]) else $error("window priority wrong");
    chk_cur_enable: assert property (wr && idx == `ACWIN_IDX_CURR_CTRL |=> ##[0:1]
        current_enable == wd_r[7]) else $error("current enable wrong");
    chk_cur_double: assert property (wr && idx == `ACWIN_IDX_CURR_CTRL |=> ##[0:1]
        current_double == wd_r[6]) else $error("current double wrong");
    chk_src_route: assert property (wr && idx == `ACWIN_IDX_CURR_CTRL |=> ##[0:1]
        {cmp1_source_out, cmp0_source_out} == wd_r[1:0]) else $error("source route wrong");
    chk_trim_value: assert property (wr && idx == `ACWIN_IDX_CURR_TRIM |=> ##[0:1]
        source_trim_value == wd_r[3:0]) else $error("trim value wrong");
    chk_req_level: assert property (irq_request[2] |->
        window_irq_priority != 2'h0 || $past(window_irq_priority) != 2'h0)
        else $error("window request with zero level");
endmodule : acwin_regs_chk

// *** tb/tb_top.sv ***
/* Self-checking bench of the comparator window bank over APB.
   Assumes design and checker compiled first; flag stages settle in ten cycles. */
`timescale 1ns/1ps
`include "acwin_params.svh"
`define CMP(nm, e, g) begin check_count++; if ((g) !== (e)) begin error_cnt++; \
    $display("ERROR %s expected %h seen %h", nm, e, g); end end

module tb_top;
    localparam int ADDR_W = 12;
    logic              pclk = 1'b0;
    logic              presetn, psel, penable, pwrite, cmp0_raw, cmp1_raw, pready, pslverr, e;
    logic              window_enable, current_enable, current_double, irq;
    logic              cmp0_source_out, cmp1_source_out;
    logic [ADDR_W-1:0] paddr;
    logic [31:0]       pwdata, prdata, q;
    logic [3:0]        pstrb, source_trim_value;
    logic [2:0]        vector_ack, irq_request;
    logic [6:0]        scale_numerator;
    logic [1:0]        window_irq_priority;
    logic [7:0]        wi [4] = '{8'h05, 8'h06, 8'h08, 8'h09};
    logic [7:0]        wm [4] = '{8'h3F, 8'h1F, 8'hC3, 8'h0F};
    int                error_cnt = 0;
    int                check_count = 0;

    acwin_regs #(.ADDR_W(ADDR_W)) dut (.pclk(pclk), .presetn(presetn), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb),
        .prdata(prdata), .pready(pready), .pslverr(pslverr), .cmp0_raw(cmp0_raw),
        .cmp1_raw(cmp1_raw), .vector_ack(vector_ack), .cmp0_enable_hyst_unused_n(),
        .cmp0_enable(), .cmp1_enable(), .cmp0_hysteresis(), .cmp1_hysteresis(),
        .cmp0_positive_input_select(), .cmp1_positive_input_select(),
        .cmp0_negative_input_select(), .cmp1_negative_input_select(), .cmp0_pin_out(),
        .cmp1_pin_out(), .window_enable(window_enable), .scale_numerator(scale_numerator),
        .current_enable(current_enable), .current_double(current_double),
        .cmp0_source_out(cmp0_source_out), .cmp1_source_out(cmp1_source_out),
        .source_trim_value(source_trim_value), .irq_request(irq_request),
        .cmp0_irq_priority(), .cmp1_irq_priority(),
        .window_irq_priority(window_irq_priority), .irq(irq));

    always #5 pclk = ~pclk;
    ////////////////////////////////////////////////////////////////////////////////
    task automatic end_sim();
        $display("checks %0d errors %0d", check_count, error_cnt);
        if (error_cnt == 0 && check_count > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask : end_sim

    // One APB transfer; an idle cycle follows so strobes never change twice at once
    task automatic apb(input logic w, input logic [7:0] i, input logic [7:0] d);
        int n;
        psel    <= 1'b1;
        pwrite  <= w;
        paddr   <= ADDR_W'({i, 2'b00});
        pwdata  <= {24'h0, d};
        @(posedge pclk);
        penable <= 1'b1;
        n = 0;
        do begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'b1 && n < 16);
        q = prdata;
        e = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
        if (pready !== 1'b1) begin
            error_cnt++;
            end_sim();
        end
        @(posedge pclk);
    endtask : apb

    task automatic rdc(input logic [7:0] i, input logic [7:0] x);
        apb(1'b0, i, 8'h00);
        `CMP("read data", {24'h0, x}, q)
    endtask : rdc
    ////////////////////////////////////////////////////////////////////////////////
    initial begin
        {presetn, psel, penable, pwrite, cmp0_raw, cmp1_raw} = 6'h00;
        paddr = '0;
        pwdata = 32'h0;
        pstrb = 4'hF;
        vector_ack = 3'h0;
        repeat (16) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        for (int i = 5; i <= 9; i++) begin
            rdc(8'(i), `ACWIN_RST_BYTE);
        end
        foreach (wi[k]) begin
            apb(1'b1, wi[k], 8'hFF);
            rdc(wi[k], wm[k]);
        end
        `CMP("numerator", 7'h40, scale_numerator)
        `CMP("window on", 1'b1, window_enable)
        `CMP("window level", 2'h3, window_irq_priority)
        `CMP("source on", 1'b1, current_enable)
        `CMP("double", 1'b1, current_double)
        `CMP("routes", 2'h3, {cmp1_source_out, cmp0_source_out})
        `CMP("trim", 4'hF, source_trim_value)
        apb(1'b1, `ACWIN_IDX_SCALER, 8'h00);
        apb(1'b1, `ACWIN_IDX_WINDOW, 8'h00);
        `CMP("numerator", 7'h01, scale_numerator)
        // Window enabled with outside condition while both levels low set the flag
        rdc(`ACWIN_IDX_STATUS, 8'h04);
        apb(1'b1, `ACWIN_IDX_STATUS, 8'h07);
        apb(1'b0, 8'h0B, 8'h00);
        `CMP("unmapped error", 1'b1, e)
        apb(1'b1, `ACWIN_IDX_IRQ_MASK, 8'h07);
        apb(1'b1, `ACWIN_IDX_CMP0_CTRL, 8'hD1);
        apb(1'b1, `ACWIN_IDX_CMP1_CTRL, 8'h01);
        cmp0_raw <= 1'b1;
        repeat (10) @(posedge pclk);
        rdc(`ACWIN_IDX_STATUS, 8'h11);
        `CMP("request", 3'h1, irq_request)
        apb(1'b1, `ACWIN_IDX_STATUS, 8'h01);
        rdc(`ACWIN_IDX_STATUS, 8'h10);
        cmp0_raw <= 1'b0;
        repeat (10) @(posedge pclk);
        rdc(`ACWIN_IDX_STATUS, 8'h00);
        cmp0_raw <= 1'b1;
        repeat (10) @(posedge pclk);
        vector_ack <= 3'h1;
        @(posedge pclk);
        vector_ack <= 3'h0;
        rdc(`ACWIN_IDX_STATUS, 8'h10);
        cmp0_raw <= 1'b0;
        apb(1'b1, `ACWIN_IDX_WINDOW, 8'h15);
        cmp1_raw <= 1'b1;
        repeat (10) @(posedge pclk);
        rdc(`ACWIN_IDX_STATUS, 8'h66);
        `CMP("request", 3'h4, irq_request)
        `CMP("irq", 1'b1, irq)
        apb(1'b1, `ACWIN_IDX_IRQ_MASK, 8'h00);
        repeat (2) @(posedge pclk);
        `CMP("masked irq", 1'b0, irq)
        apb(1'b1, `ACWIN_IDX_STATUS, 8'h07);
        rdc(`ACWIN_IDX_STATUS, 8'h60);
        apb(1'b1, `ACWIN_IDX_WINDOW, 8'h00);
        rdc(`ACWIN_IDX_STATUS, 8'h20);
        end_sim();
    end
endmodule : tb_top

bind acwin_regs acwin_regs_chk #(.ADDR_W(ADDR_W)) u_chk (.pclk(pclk), .presetn(presetn),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .pstrb(pstrb), .pready(pready), .pslverr(pslverr), .scale_numerator(scale_numerator),
    .window_enable(window_enable), .current_enable(current_enable),
    .current_double(current_double), .cmp0_source_out(cmp0_source_out),
    .cmp1_source_out(cmp1_source_out), .source_trim_value(source_trim_value),
    .irq_request(irq_request), .window_irq_priority(window_irq_priority));
